// >>> shared/psia_pkg.sv
package psia_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W      = 13;
  localparam int LOW_W     = 8;
  localparam int LATH_W    = 5;
  localparam int FPTR_W    = 8;
  localparam int DADR_W    = 9;
  localparam int LIT_W     = 11;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam int WB_ADR_W  = 8;
  localparam int WB_DAT_W  = 32;

  // ----------------------------------------------------------------
  // register offsets (byte addresses) and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PC_LOW = 8'h00;
  localparam logic [7:0] OFS_LATH   = 8'h04;
  localparam logic [7:0] OFS_FPTR   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int         BANK_BIT   = 7;

  // ----------------------------------------------------------------
  // values after reset and fixed codes
  // ----------------------------------------------------------------
  localparam logic [12:0] RST_PC    = 13'h0000;
  localparam logic [4:0]  RST_LATH  = 5'h00;
  localparam logic [7:0]  RST_FPTR  = 8'h00;
  localparam logic        RST_BANK  = 1'b0;
  localparam logic [2:0]  RST_PTR   = 3'h0;
  localparam logic [12:0] PC_ONE    = 13'h0001;
  localparam logic [2:0]  PTR_ONE   = 3'h1;
  localparam logic [6:0]  IND_LOW   = 7'h00;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // program flow operations issued by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE,
    OP_STEP,
    OP_GOTO,
    OP_CALL,
    OP_RET,
    OP_LOW_WR,
    OP_INT
  } psia_op_t;

endpackage : psia_pkg

// >>> rtl/psia_stack.sv
`timescale 1ns/1ps

module psia_stack (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [12:0] push_data_i,
  output logic      [12:0] top_o
);

  logic [2:0]  ptr;
  logic [2:0]  next_ptr;
  logic [12:0] entry [psia_pkg::STK_DEPTH];

  // ----------------------------------------------------------------
  // pointer, wraps silently both ways
  // ----------------------------------------------------------------
  always_comb begin
    next_ptr = ptr;
    if (push_i && !pop_i) begin
      next_ptr = ptr + psia_pkg::PTR_ONE;
    end else if (pop_i && !push_i) begin
      next_ptr = ptr - psia_pkg::PTR_ONE;
    end
  end

  // pointer register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr <= psia_pkg::RST_PTR;
    end else begin
      ptr <= next_ptr;
    end
  end

  // ----------------------------------------------------------------
  // entries: a push overwrites the slot under the pointer
  // ----------------------------------------------------------------
  for (genvar i = 0; i < psia_pkg::STK_DEPTH; i++) begin : gen_entry
    logic [12:0] next_entry;

    // ninth push lands on the first slot again
    always_comb begin
      next_entry = entry[i];
      if (push_i && (ptr == 3'(i))) begin
        next_entry = push_data_i;
      end
    end

    // entry register
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        entry[i] <= psia_pkg::RST_PC;
      end else begin
        entry[i] <= next_entry;
      end
    end
  end

  // most recent push
  assign top_o = entry[ptr - psia_pkg::PTR_ONE];

endmodule : psia_stack

// >>> rtl/psia_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// - program counter is 13 bits; low byte readable and writable.
// - upper five bits are never written directly; low byte writes load all five from the high latch.
// - any reset clears the whole program counter.
// - writing the low byte copies all five latch bits into the top.
// - call and goto take top two bits from latch bits 4 and 3.
// - low byte rollover never carries into the high latch.
// - return stack has eight entries of thirteen bits.
// - stack and its pointer are invisible to software.
// - calls and interrupt vectoring push the program counter.
// - the one return op pops into the program counter.
// - pushes and pops leave the high latch alone.
// - stack is circular; ninth push overwrites the first.
// - no overflow or underflow flag exists.
// - indirect port has no storage; it accesses the pointed location.
// - indirect read of the port itself returns zero.
// - indirect write of the port itself changes no data.
// - indirect address is bank bit above the eight pointer bits.

module psia_top #(
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // program flow from the decoder
  input  wire logic                     instr_valid_i,
  input  wire psia_pkg::psia_op_t       op_i,
  input  wire logic [10:0]              lit_i,
  input  wire logic [7:0]               pc_low_data_i,
  output logic      [12:0]              pc_o,
  // data access from the decoder
  input  wire logic [8:0]               dat_addr_i,
  input  wire logic                     dat_rd_i,
  input  wire logic                     dat_wr_i,
  input  wire logic [7:0]               dat_wdata_i,
  output logic      [7:0]               dat_rdata_o,
  output logic                          dat_rvalid_o,
  // data memory
  output logic      [8:0]               mem_addr_o,
  output logic                          mem_rd_o,
  output logic                          mem_wr_o,
  output logic      [7:0]               mem_wdata_o,
  input  wire logic [7:0]               mem_rdata_i
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        wb_req;
  logic        wb_wr_fire;
  logic        next_ack;
  logic [31:0] next_rdat;

  logic [4:0]  hi_latch;
  logic [7:0]  fptr;
  logic        bank;
  logic [4:0]  next_hi_latch;
  logic [7:0]  next_fptr;
  logic        next_bank;

  logic [12:0] pc;
  logic [12:0] next_pc;
  logic        stk_push;
  logic        stk_pop;
  logic [12:0] stk_push_data;
  logic [12:0] stk_top;

  logic        is_ind_port;
  logic        fptr_self;
  logic        blocked;
  logic [8:0]  next_mem_addr;
  logic        next_mem_rd;
  logic        next_mem_wr;
  logic [7:0]  next_mem_wdata;
  logic        rd_pend;
  logic        rd_zero;
  logic        next_rd_pend;
  logic        next_rd_zero;
  logic [7:0]  next_dat_rdata;
  logic        next_dat_rvalid;

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------

  // request and write commit; a write lands at the acknowledging edge
  assign wb_req     = wb_cyc_i & wb_stb_i;
  assign wb_wr_fire = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // one wait cycle, then ack for one cycle; unmapped reads give zero
  always_comb begin
    next_ack  = wb_req & ~wb_ack_o;
    next_rdat = wb_dat_o;
    if (wb_req && !wb_ack_o) begin
      next_rdat = '0;
      case (wb_adr_i)
        psia_pkg::OFS_PC_LOW: begin
          next_rdat[7:0] = pc[7:0];
        end
        psia_pkg::OFS_LATH: begin
          next_rdat[4:0] = hi_latch;
        end
        psia_pkg::OFS_FPTR: begin
          next_rdat[7:0] = fptr;
        end
        psia_pkg::OFS_STATUS: begin
          next_rdat[psia_pkg::BANK_BIT] = bank;
        end
        default: begin
          next_rdat = '0; // no stack view here
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdat;
    end
  end

  // ----------------------------------------------------------------
  // software registers: high latch, file pointer, bank bit
  // ----------------------------------------------------------------

  // only bus writes touch these; stack traffic never does
  always_comb begin
    next_hi_latch = hi_latch;
    next_fptr     = fptr;
    next_bank     = bank;
    if (wb_wr_fire) begin
      case (wb_adr_i)
        psia_pkg::OFS_LATH: begin
          next_hi_latch = wb_dat_i[4:0];
        end
        psia_pkg::OFS_FPTR: begin
          next_fptr = wb_dat_i[7:0];
        end
        psia_pkg::OFS_STATUS: begin
          next_bank = wb_dat_i[psia_pkg::BANK_BIT];
        end
        default: begin
          next_hi_latch = hi_latch;
        end
      endcase
    end
  end

  // software register storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_latch <= psia_pkg::RST_LATH;
      fptr     <= psia_pkg::RST_FPTR;
      bank     <= psia_pkg::RST_BANK;
    end else begin
      hi_latch <= next_hi_latch;
      fptr     <= next_fptr;
      bank     <= next_bank;
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------

  // decoder operation wins over a bus write of the low byte
  always_comb begin
    next_pc       = pc;
    stk_push      = 1'b0;
    stk_pop       = 1'b0;
    stk_push_data = pc;
    if (instr_valid_i) begin
      case (op_i)
        psia_pkg::OP_STEP: begin
          next_pc = pc + psia_pkg::PC_ONE;
        end
        psia_pkg::OP_GOTO: begin
          next_pc = {hi_latch[4:3], lit_i};
        end
        psia_pkg::OP_CALL: begin
          stk_push      = 1'b1;
          stk_push_data = pc + psia_pkg::PC_ONE;
          next_pc       = {hi_latch[4:3], lit_i};
        end
        psia_pkg::OP_RET: begin
          stk_pop = 1'b1;
          next_pc = stk_top;
        end
        psia_pkg::OP_LOW_WR: begin
          // alu result is eight bits; no carry reaches the top
          next_pc = {hi_latch, pc_low_data_i};
        end
        psia_pkg::OP_INT: begin
          stk_push      = 1'b1;
          stk_push_data = pc;
          next_pc       = INT_VECTOR;
        end
        default: begin
          next_pc = pc;
        end
      endcase
    end else if (wb_wr_fire && (wb_adr_i == psia_pkg::OFS_PC_LOW)) begin
      next_pc = {hi_latch, wb_dat_i[7:0]};
    end
  end

  // counter register, cleared by reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= psia_pkg::RST_PC;
    end else begin
      pc <= next_pc;
    end
  end

  assign pc_o = pc;

  // ----------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------

  // private storage, no flags out
  psia_stack u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (stk_push),
    .pop_i       (stk_pop),
    .push_data_i (stk_push_data),
    .top_o       (stk_top)
  );

  // ----------------------------------------------------------------
  // indirect data addressing
  // ----------------------------------------------------------------

  // indirect port is decoded in every bank by its low seven bits
  assign is_ind_port = (dat_addr_i[6:0] == psia_pkg::IND_LOW);
  assign fptr_self   = (fptr[6:0] == psia_pkg::IND_LOW);
  assign blocked     = is_ind_port & fptr_self;

  // translate the address, drop self-pointing accesses
  always_comb begin
    next_mem_addr  = dat_addr_i;
    next_mem_wdata = dat_wdata_i;
    if (is_ind_port) begin
      next_mem_addr = {bank, fptr};
    end
    next_mem_rd  = dat_rd_i & ~blocked;
    next_mem_wr  = dat_wr_i & ~blocked;
    next_rd_pend = dat_rd_i;
    next_rd_zero = dat_rd_i & blocked;
  end

  // memory request register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o  <= '0;
      mem_rd_o    <= 1'b0;
      mem_wr_o    <= 1'b0;
      mem_wdata_o <= psia_pkg::ZERO_BYTE;
      rd_pend     <= 1'b0;
      rd_zero     <= 1'b0;
    end else begin
      mem_addr_o  <= next_mem_addr;
      mem_rd_o    <= next_mem_rd;
      mem_wr_o    <= next_mem_wr;
      mem_wdata_o <= next_mem_wdata;
      rd_pend     <= next_rd_pend;
      rd_zero     <= next_rd_zero;
    end
  end

  // read return: memory answers in the cycle the request stands
  always_comb begin
    next_dat_rvalid = rd_pend;
    next_dat_rdata  = dat_rdata_o;
    if (rd_pend) begin
      if (rd_zero) begin
        next_dat_rdata = psia_pkg::ZERO_BYTE;
      end else begin
        next_dat_rdata = mem_rdata_i;
      end
    end
  end

  // read return register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_rdata_o  <= psia_pkg::ZERO_BYTE;
      dat_rvalid_o <= 1'b0;
    end else begin
      dat_rdata_o  <= next_dat_rdata;
      dat_rvalid_o <= next_dat_rvalid;
    end
  end

endmodule : psia_top

// >>> tb/psia_asserts.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port checks for pc, data access and bus ack
// ----------------------------------------------------------------
module psia_asserts #(
  parameter logic [12:0] INT_VECTOR = 13'h0004
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               instr_valid_i,
  input wire psia_pkg::psia_op_t op_i,
  input wire logic [10:0]        lit_i,
  input wire logic [7:0]         pc_low_data_i,
  input wire logic [12:0]        pc_o,
  input wire logic [8:0]         dat_addr_i,
  input wire logic               dat_rd_i,
  input wire logic               dat_wr_i,
  input wire logic [7:0]         dat_wdata_i,
  input wire logic               dat_rvalid_o,
  input wire logic [8:0]         mem_addr_o,
  input wire logic               mem_rd_o,
  input wire logic               mem_wr_o,
  input wire logic [7:0]         mem_wdata_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // pc reaction to decoder ops and reset
  a_rst_clear: assert property (disable iff (1'b0)
    rst_i |=> pc_o == 13'h0000) else $error("pc not cleared");
  a_step_incr: assert property (
    instr_valid_i && op_i == psia_pkg::OP_STEP
    |=> pc_o == $past(pc_o) + 13'h0001) else $error("bad step");
  a_jump_low: assert property (
    instr_valid_i && op_i inside {psia_pkg::OP_GOTO, psia_pkg::OP_CALL}
    |=> pc_o[10:0] == $past(lit_i)) else $error("bad jump");
  a_low_load: assert property (
    instr_valid_i && op_i == psia_pkg::OP_LOW_WR
    |=> pc_o[7:0] == $past(pc_low_data_i)) else $error("bad low load");
  a_int_vector: assert property (
    instr_valid_i && op_i == psia_pkg::OP_INT
    |=> pc_o == INT_VECTOR) else $error("bad vector");
  a_pc_idle: assert property (
    !instr_valid_i && !wb_cyc_i |=> $stable(pc_o)) else $error("pc moved");
  // data path timing and addressing, bus ack timing
  a_direct_rd: assert property (
    dat_rd_i && dat_addr_i[6:0] != 7'h00
    |=> mem_rd_o && mem_addr_o == $past(dat_addr_i)) else $error("bad rd");
  a_direct_wr: assert property (
    dat_wr_i && dat_addr_i[6:0] != 7'h00
    |=> mem_wr_o && mem_wdata_o == $past(dat_wdata_i)) else $error("bad wr");
  a_rvalid_late: assert property (
    dat_rd_i |-> ##2 dat_rvalid_o) else $error("rvalid late");
  a_ack_once: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad ack");
  c_call: cover property (instr_valid_i && op_i == psia_pkg::OP_CALL);
  c_int: cover property (instr_valid_i && op_i == psia_pkg::OP_INT);
  c_ind: cover property (dat_rd_i && dat_addr_i[6:0] == 7'h00);
endmodule : psia_asserts

bind psia_top psia_asserts #(.INT_VECTOR(INT_VECTOR)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .instr_valid_i(instr_valid_i), .op_i(op_i), .lit_i(lit_i),
  .pc_low_data_i(pc_low_data_i), .pc_o(pc_o), .dat_addr_i(dat_addr_i),
  .dat_rd_i(dat_rd_i), .dat_wr_i(dat_wr_i), .dat_wdata_i(dat_wdata_i),
  .dat_rvalid_o(dat_rvalid_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o));

// >>> tb/psia_dmem.sv
`timescale 1ns/1ps

// data memory beside the block
module psia_dmem (
  input  wire logic       clk_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [512];
  logic [7:0] last = 8'h5a;
  // data only while strobed, otherwise a changing pattern
  assign rdata_o = rd_i ? mem[addr_i] : ~last;
  // store writes and remember the last byte shown
  always @(posedge clk_i) begin
    if (wr_i) mem[addr_i] <= wdata_i;
    last <= rdata_o;
  end
endmodule : psia_dmem

// >>> tb/psia_top_tb.sv
`timescale 1ns/1ps

module psia_top_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, iv, drd, dwr, rvld;
  logic        mrd, mwr;
  logic [7:0]  adr, lowb_d, mwd, mrdt, dwd, drdt;
  logic [3:0]  sel, wsel;
  logic [31:0] wdat, rdat, got;
  logic [10:0] lit;
  logic [12:0] pc, epc;
  logic [12:0] stk [8];
  logic [8:0]  daddr, maddr;
  logic [2:0]  sp;
  int          errors, check_count, cycles, wr_count, n;
  psia_pkg::psia_op_t op;

  psia_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .instr_valid_i(iv), .op_i(op),
    .lit_i(lit), .pc_low_data_i(lowb_d), .pc_o(pc), .dat_addr_i(daddr),
    .dat_rd_i(drd), .dat_wr_i(dwr), .dat_wdata_i(dwd),
    .dat_rdata_o(drdt), .dat_rvalid_o(rvld), .mem_addr_o(maddr),
    .mem_rd_o(mrd), .mem_wr_o(mwr), .mem_wdata_o(mwd),
    .mem_rdata_i(mrdt));
  psia_dmem u_mem (.clk_i(clk_i), .addr_i(maddr), .rd_i(mrd),
    .wr_i(mwr), .wdata_i(mwd), .rdata_o(mrdt));

  // clock, write count and hang guard
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (mwr === 1'b1) wr_count++;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // one classic bus cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    wdat <= d;
    // only the global cycle ceiling ends a missing answer
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clk_i);
  endtask : wb

  // one decoder op, pc settled on return
  task automatic run(input psia_pkg::psia_op_t o, input logic [10:0] l,
                     input logic [7:0] d);
    @(posedge clk_i);
    iv <= 1'b1;
    op <= o;
    lit <= l;
    lowb_d <= d;
    @(posedge clk_i);
    iv <= 1'b0;
    op <= psia_pkg::OP_NONE;
    @(negedge clk_i);
  endtask : run

  // one data access, read waits for rvalid
  task automatic dacc(input logic w, input logic [8:0] a,
                      input logic [7:0] d);
    @(posedge clk_i);
    drd <= !w;
    dwr <= w;
    daddr <= a;
    dwd <= d;
    @(posedge clk_i);
    drd <= 1'b0;
    dwr <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (!w && rvld !== 1'b1);
  endtask : dacc

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    {rst_i, cyc, stb, we, iv, drd, dwr} = 7'h40;
    {adr, wdat, lit, lowb_d, daddr, dwd} = '0;
    sel = 4'h1;
    wsel = 4'h1;
    op = psia_pkg::OP_NONE;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(pc, 13'h0000);
    wb(1'b1, psia_pkg::OFS_LATH, 32'h1b);
    wb(1'b1, psia_pkg::OFS_PC_LOW, 32'h34);
    chk(pc, 13'h1b34);
    wb(1'b0, psia_pkg::OFS_PC_LOW, 0);
    chk(got, 32'h34);
    wb(1'b0, 8'h40, 0);
    chk(got, 32'h0);
    run(psia_pkg::OP_LOW_WR, 0, 8'h00);
    chk(pc, 13'h1b00);
    wb(1'b0, psia_pkg::OFS_LATH, 0);
    chk(got, 32'h1b);
    run(psia_pkg::OP_LOW_WR, 0, 8'hff);
    run(psia_pkg::OP_STEP, 0, 0);
    chk(pc, 13'h1c00);
    wb(1'b1, psia_pkg::OFS_LATH, 32'h1f);
    run(psia_pkg::OP_LOW_WR, 0, 8'hff);
    run(psia_pkg::OP_STEP, 0, 0);
    chk(pc, 13'h0000);
    wb(1'b1, psia_pkg::OFS_LATH, 32'h1b);
    run(psia_pkg::OP_GOTO, 11'h5a5, 0);
    chk(pc, 13'h1da5);
    $display("pc load test done");
    epc = pc;
    sp = 3'h0;
    for (int i = 1; i <= 9; i++) begin
      stk[sp] = epc + 13'h0001;
      sp++;
      epc = {2'b11, 11'(i * 16 + 3)};
      run(psia_pkg::OP_CALL, epc[10:0], 0);
      chk(pc, epc);
    end
    for (int i = 0; i < 9; i++) begin
      sp--;
      epc = stk[sp];
      run(psia_pkg::OP_RET, 0, 0);
      chk(pc, epc);
    end
    run(psia_pkg::OP_INT, 0, 0);
    chk(pc, 13'h0004);
    run(psia_pkg::OP_RET, 0, 0);
    chk(pc, epc);
    wb(1'b0, psia_pkg::OFS_LATH, 0);
    chk(got, 32'h1b);
    // a write with byte lane 0 disabled must leave the latch alone
    wsel = 4'h0;
    wb(1'b1, psia_pkg::OFS_LATH, 32'h05);
    wsel = 4'h1;
    wb(1'b0, psia_pkg::OFS_LATH, 0);
    chk(got, 32'h1b);
    $display("stack test done");
    wb(1'b1, psia_pkg::OFS_FPTR, 32'h45);
    wb(1'b1, psia_pkg::OFS_STATUS, 32'h80);
    dacc(1'b1, 9'h145, 8'ha7);
    dacc(1'b0, 9'h000, 0);
    chk(drdt, 8'ha7);
    dacc(1'b1, 9'h080, 8'h5e);
    dacc(1'b0, 9'h145, 0);
    chk(drdt, 8'h5e);
    wb(1'b1, psia_pkg::OFS_FPTR, 32'h80);
    dacc(1'b0, 9'h000, 0);
    chk(drdt, 8'h00);
    n = wr_count;
    dacc(1'b1, 9'h000, 8'h33);
    repeat (2) @(posedge clk_i);
    chk(wr_count, n);
    $display("indirect test done");
    // reset in mid-run while the counter holds a nonzero value
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(pc, 13'h0000);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : psia_top_tb
